// ---- hw/ssr_pkg.sv ----
// Shared constants of the serial port status, prescale and interrupt block.
// Assumes a 125 MHz system clock and a word-aligned register port.

package ssr_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_DATA = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_PRESCALE = 12'h010;
  localparam logic [11:0] OFS_MASK = 12'h014;
  localparam logic [11:0] OFS_RAW = 12'h018;
  localparam logic [11:0] OFS_MASKED = 12'h01C;
  localparam logic [11:0] OFS_CLEAR = 12'h020;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ST_BUSY = 4;
  localparam int ST_RX_FULL = 3;
  localparam int ST_RX_NONEMPTY = 2;
  localparam int ST_TX_SPACE = 1;
  localparam int ST_TX_EMPTY = 0;
  localparam int IRQ_TX_LEVEL = 3;
  localparam int IRQ_RX_LEVEL = 2;
  localparam int IRQ_RX_TIMEOUT = 1;
  localparam int IRQ_RX_OVERRUN = 0;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [3:0] MASK_RST = 4'h0;
  // Idle levels of {link clock, select_n, data in}; synchronisers start here
  localparam logic [2:0] PINS_IDLE = 3'b010;

  // ----------------------------------------------------------------------
  // Timing and frame size
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int RX_TIMEOUT_NS = 5120;
  localparam int RX_TIMEOUT_CYC = (RX_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAME_BITS = 8;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [0:0] {
    LNK_IDLE = 1'b0,
    LNK_SHIFT = 1'b1
  } ssr_link_e;

endpackage : ssr_pkg

// ---- hw/ssr_fifo_mem.sv ----
// Small storage array for one FIFO, with registered read data.
// Assumes the caller keeps pointers and counts and never writes when full.

module ssr_fifo_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] q_r;

  // ----------------------------------------------------------------------
  // Array write and registered read
  // ----------------------------------------------------------------------
  // The array carries no reset, so it maps onto plain storage
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // Read port follows the next read pointer so the head is valid at once
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q_r <= '0;
    end else begin
      q_r <= mem_r[rd_addr];
    end
  end

  assign rd_data = q_r;

endmodule : ssr_fifo_mem

// ---- hw/ssr_sync.sv ----
// Two flip-flop synchroniser for a group of slow pin levels.
// Assumes each bit is a level that stays put for several system clocks.

module ssr_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ssr_sync_s;

  ssr_sync_s st_r;
  ssr_sync_s st_nxt;

  // ----------------------------------------------------------------------
  // Two stages
  // ----------------------------------------------------------------------
  // First stage feeds only the second stage
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      // Start at the pins' idle levels, else a false select follows reset
      st_r <= {RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;

endmodule : ssr_sync

// ---- hw/ssr_status_irq.sv ----
// Status, prescaler and interrupt logic of a synchronous serial port,
// with its FIFOs and a minimal frame shifter that face a sampled link.
// Assumes a single-cycle register port and a link clock far slower than clk_sys.

module ssr_status_irq #(
  parameter int DEPTH = ssr_pkg::FIFO_DEPTH,
  parameter int TIMEOUT_CYC = ssr_pkg::RX_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [11:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  output logic irq_out,
  input wire logic link_clk_in,
  input wire logic link_sel_n_in,
  input wire logic link_mosi_in,
  output logic link_miso_out,
  output logic link_miso_oe,
  output logic bit_rate_tick
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int FB = ssr_pkg::FRAME_BITS;

  typedef struct packed {
    ssr_pkg::ssr_link_e link;
    logic clk_d;
    logic [2:0] bit_cnt;
    logic [FB-1:0] tx_sh;
    logic [FB-1:0] rx_sh;
    logic load_pend;
    logic [PW-1:0] tx_wptr;
    logic [PW-1:0] tx_rptr;
    logic [CW-1:0] tx_cnt;
    logic tx_pend;
    logic [PW-1:0] rx_wptr;
    logic [PW-1:0] rx_rptr;
    logic [CW-1:0] rx_cnt;
    logic rx_pend;
    logic [7:0] prescale;
    logic [7:0] pre_cnt;
    logic tick;
    logic [3:0] mask;
    logic rt_latch;
    logic ror_latch;
    logic [TW-1:0] to_cnt;
    logic miso;
    logic miso_oe;
    logic irq;
    logic [31:0] rdata;
  } ssr_state_s;

  ssr_state_s st_r;
  ssr_state_s st_nxt;

  logic [2:0] pins_s;
  logic clk_s;
  logic sel_s;
  logic mosi_s;
  logic [FB-1:0] tx_q;
  logic [FB-1:0] rx_q;
  logic tx_we;
  logic rx_we;
  logic [FB-1:0] rx_wdata;
  logic [CW-1:0] tx_occ;
  logic [CW-1:0] rx_occ;
  logic [4:0] status_cur;
  logic [3:0] raw_cur;
  logic [3:0] masked_cur;
  logic byte_done;
  logic ovr_event;
  logic rt_event;
  logic tx_pop;
  logic rx_pop;

  // Decoding shared by reads, writes and checks
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // ----------------------------------------------------------------------
  // Link pin synchronisers and FIFO storage
  // ----------------------------------------------------------------------
  ssr_sync #(.WIDTH(3), .RST_VAL(ssr_pkg::PINS_IDLE)) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .async_in({link_clk_in, link_sel_n_in, link_mosi_in}),
    .sync_out(pins_s)
  );

  assign clk_s = pins_s[2];
  assign sel_s = ~pins_s[1];
  assign mosi_s = pins_s[0];

  ssr_fifo_mem #(.WIDTH(FB), .DEPTH(DEPTH)) u_tx_mem (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wr_en(tx_we),
    .wr_addr(st_r.tx_wptr),
    .wr_data(bus_wdata[FB-1:0]),
    .rd_addr(st_nxt.tx_rptr),
    .rd_data(tx_q)
  );

  ssr_fifo_mem #(.WIDTH(FB), .DEPTH(DEPTH)) u_rx_mem (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wr_en(rx_we),
    .wr_addr(st_r.rx_wptr),
    .wr_data(rx_wdata),
    .rd_addr(st_nxt.rx_rptr),
    .rd_data(rx_q)
  );

  // ----------------------------------------------------------------------
  // Status views of the current state
  // ----------------------------------------------------------------------
  // A receive push becomes visible one cycle late so the registered head is valid
  always_comb begin
    tx_occ = st_r.tx_cnt + CW'(st_r.tx_pend);
    rx_occ = st_r.rx_cnt + CW'(st_r.rx_pend);
    status_cur = '0;
    status_cur[ssr_pkg::ST_BUSY] = (st_r.link == ssr_pkg::LNK_SHIFT) || (tx_occ != '0);
    status_cur[ssr_pkg::ST_RX_FULL] = (st_r.rx_cnt == CW'(DEPTH));
    status_cur[ssr_pkg::ST_RX_NONEMPTY] = (st_r.rx_cnt != '0);
    status_cur[ssr_pkg::ST_TX_SPACE] = (tx_occ != CW'(DEPTH));
    status_cur[ssr_pkg::ST_TX_EMPTY] = (tx_occ == '0);
    raw_cur = '0;
    raw_cur[ssr_pkg::IRQ_TX_LEVEL] = (tx_occ <= CW'(DEPTH / 2));
    raw_cur[ssr_pkg::IRQ_RX_LEVEL] = (st_r.rx_cnt >= CW'(DEPTH / 2));
    raw_cur[ssr_pkg::IRQ_RX_TIMEOUT] = st_r.rt_latch;
    raw_cur[ssr_pkg::IRQ_RX_OVERRUN] = st_r.ror_latch;
    masked_cur = raw_cur & st_r.mask;
  end

  // ----------------------------------------------------------------------
  // Next state: link shifter, FIFOs, registers, interrupt
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    st_nxt.rdata = '0;
    st_nxt.clk_d = clk_s;
    tx_pop = 1'b0;
    rx_pop = bus_rd && hit(bus_addr, ssr_pkg::OFS_DATA) && (st_r.rx_cnt != '0);
    tx_we = bus_wr && hit(bus_addr, ssr_pkg::OFS_DATA) && (tx_occ != CW'(DEPTH));
    byte_done = 1'b0;
    rx_wdata = {st_r.rx_sh[FB-2:0], mosi_s};

    // Frame shifter, receive on rising edge, drive on falling edge
    unique case (st_r.link)
      ssr_pkg::LNK_IDLE: begin
        if (sel_s) begin
          st_nxt.link = ssr_pkg::LNK_SHIFT;
          st_nxt.bit_cnt = '0;
          st_nxt.load_pend = 1'b0;
          tx_pop = (st_r.tx_cnt != '0);
          st_nxt.tx_sh = tx_pop ? tx_q : '0;
          st_nxt.miso = st_nxt.tx_sh[FB-1];
          st_nxt.miso_oe = 1'b1;
        end
      end
      ssr_pkg::LNK_SHIFT: begin
        if (!sel_s) begin
          // A partial byte at the end of a frame is dropped
          st_nxt.link = ssr_pkg::LNK_IDLE;
          st_nxt.miso = 1'b0;
          st_nxt.miso_oe = 1'b0;
        end else if (clk_s && !st_r.clk_d) begin
          st_nxt.rx_sh = rx_wdata;
          st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
          byte_done = (st_r.bit_cnt == 3'(FB - 1));
          st_nxt.load_pend = byte_done;
        end else if (!clk_s && st_r.clk_d) begin
          if (st_r.load_pend) begin
            tx_pop = (st_r.tx_cnt != '0);
            st_nxt.tx_sh = tx_pop ? tx_q : '0;
            st_nxt.load_pend = 1'b0;
          end else begin
            st_nxt.tx_sh = {st_r.tx_sh[FB-2:0], 1'b0};
          end
          st_nxt.miso = st_nxt.tx_sh[FB-1];
        end
      end
    endcase

    // Receive push, or overrun when no room is left
    ovr_event = byte_done && (rx_occ == CW'(DEPTH));
    rx_we = byte_done && !ovr_event;

    // Pointers and counts
    st_nxt.tx_wptr = st_r.tx_wptr + PW'(tx_we);
    st_nxt.tx_rptr = st_r.tx_rptr + PW'(tx_pop);
    st_nxt.tx_cnt = st_r.tx_cnt + CW'(st_r.tx_pend) - CW'(tx_pop);
    st_nxt.tx_pend = tx_we;
    st_nxt.rx_wptr = st_r.rx_wptr + PW'(rx_we);
    st_nxt.rx_rptr = st_r.rx_rptr + PW'(rx_pop);
    st_nxt.rx_cnt = st_r.rx_cnt + CW'(st_r.rx_pend) - CW'(rx_pop);
    st_nxt.rx_pend = rx_we;

    // Receive time-out: idle link with data left waiting
    rt_event = 1'b0;
    if ((st_r.rx_cnt == '0) || (st_r.link == ssr_pkg::LNK_SHIFT) || rx_pop) begin
      st_nxt.to_cnt = '0;
    end else if (st_r.to_cnt != TW'(TIMEOUT_CYC)) begin
      st_nxt.to_cnt = st_r.to_cnt + TW'(1);
      rt_event = (st_r.to_cnt == TW'(TIMEOUT_CYC - 1));
    end

    // Register writes; raw and masked status take none
    if (bus_wr && hit(bus_addr, ssr_pkg::OFS_PRESCALE)) begin
      st_nxt.prescale = {bus_wdata[7:1], 1'b0};
      st_nxt.pre_cnt = '0;
    end
    if (bus_wr && hit(bus_addr, ssr_pkg::OFS_MASK)) begin
      st_nxt.mask = bus_wdata[3:0];
    end

    // Latched error sources; a new event wins over a clear
    st_nxt.rt_latch = rt_event || (st_r.rt_latch && !(bus_wr && hit(bus_addr,
      ssr_pkg::OFS_CLEAR) && bus_wdata[ssr_pkg::IRQ_RX_TIMEOUT]));
    st_nxt.ror_latch = ovr_event || (st_r.ror_latch && !(bus_wr && hit(bus_addr,
      ssr_pkg::OFS_CLEAR) && bus_wdata[ssr_pkg::IRQ_RX_OVERRUN]));

    // Bit-rate prescaler; divisors below two leave it stopped
    if (st_r.prescale >= 8'h02) begin
      if (st_r.pre_cnt >= st_r.prescale - 8'h01) begin
        st_nxt.pre_cnt = '0;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.pre_cnt = st_r.pre_cnt + 8'h01;
      end
    end

    // Read data stand only in the cycle after the strobe
    if (bus_rd) begin
      unique case (1'b1)
        hit(bus_addr, ssr_pkg::OFS_DATA): begin
          st_nxt.rdata = rx_pop ? {24'h000000, rx_q} : 32'h00000000;
        end
        hit(bus_addr, ssr_pkg::OFS_STATUS): st_nxt.rdata = {27'h0000000, status_cur};
        hit(bus_addr, ssr_pkg::OFS_PRESCALE): st_nxt.rdata = {24'h000000, st_r.prescale};
        hit(bus_addr, ssr_pkg::OFS_MASK): st_nxt.rdata = {28'h0000000, st_r.mask};
        hit(bus_addr, ssr_pkg::OFS_RAW): st_nxt.rdata = {28'h0000000, raw_cur};
        hit(bus_addr, ssr_pkg::OFS_MASKED): st_nxt.rdata = {28'h0000000, masked_cur};
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end

    // Interrupt from the state about to be registered
    st_nxt.irq = ((st_nxt.tx_cnt + CW'(st_nxt.tx_pend)) <= CW'(DEPTH / 2)) &&
      st_nxt.mask[ssr_pkg::IRQ_TX_LEVEL];
    st_nxt.irq = st_nxt.irq || ((st_nxt.rx_cnt >= CW'(DEPTH / 2)) &&
      st_nxt.mask[ssr_pkg::IRQ_RX_LEVEL]);
    st_nxt.irq = st_nxt.irq || (st_nxt.rt_latch && st_nxt.mask[ssr_pkg::IRQ_RX_TIMEOUT]) ||
      (st_nxt.ror_latch && st_nxt.mask[ssr_pkg::IRQ_RX_OVERRUN]);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.prescale <= ssr_pkg::PRESCALE_RST;
      st_r.mask <= ssr_pkg::MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register
  assign bus_rdata = st_r.rdata;
  assign irq_out = st_r.irq;
  assign link_miso_out = st_r.miso;
  assign link_miso_oe = st_r.miso_oe;
  assign bit_rate_tick = st_r.tick;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  chk_prescale_even: assert property (
    bus_wr && hit(bus_addr, ssr_pkg::OFS_PRESCALE) |=>
      st_r.prescale == {$past(bus_wdata[7:1]), 1'b0})
    else $error("prescale not stored even");

  chk_mask_store: assert property (
    bus_wr && hit(bus_addr, ssr_pkg::OFS_MASK) |=> st_r.mask == $past(bus_wdata[3:0]))
    else $error("mask not stored as written");

  chk_raw_ignores: assert property (
    bus_wr && hit(bus_addr, ssr_pkg::OFS_RAW) |=> $stable(st_r.mask) && $stable(st_r.prescale))
    else $error("raw status write had an effect");

  chk_status_read: assert property (
    bus_rd && hit(bus_addr, ssr_pkg::OFS_STATUS) |=> bus_rdata == {27'h0000000, $past(status_cur)})
    else $error("status read mismatch");

  chk_busy_frame: assert property (
    st_r.link == ssr_pkg::LNK_SHIFT |-> status_cur[ssr_pkg::ST_BUSY])
    else $error("busy low during frame");

  chk_overrun_set: assert property (
    ovr_event |=> st_r.ror_latch && (st_r.rx_cnt == CW'(DEPTH) - CW'($past(rx_pop))))
    else $error("overrun not latched");

  chk_clear_timeout: assert property (
    bus_wr && hit(bus_addr, ssr_pkg::OFS_CLEAR) && bus_wdata[ssr_pkg::IRQ_RX_TIMEOUT] &&
      !rt_event |=> !st_r.rt_latch)
    else $error("timeout not cleared");

  chk_timeout_sticky: assert property (
    st_r.rt_latch && !(bus_wr && hit(bus_addr, ssr_pkg::OFS_CLEAR)) |=> st_r.rt_latch)
    else $error("timeout latch dropped");

  chk_masked_read: assert property (
    bus_rd && hit(bus_addr, ssr_pkg::OFS_MASKED) |=> bus_rdata[3:0] == $past(masked_cur))
    else $error("masked read mismatch");

  chk_irq_level: assert property (
    irq_out == (masked_cur != 4'h0))
    else $error("interrupt does not follow masked status");

  cov_frame: cover property (st_r.link == ssr_pkg::LNK_SHIFT && byte_done);
  cov_overrun: cover property (ovr_event);
  cov_timeout: cover property (rt_event ##1 irq_out);

endmodule : ssr_status_irq

// ---- sim/ssr_spi_peer.sv ----
// Behavioural model of the external peripheral that clocks frames into the port.
// Assumes a link clock idle low, data sampled on the rising edge, MSB first.

module ssr_spi_peer (
  output logic link_clk,
  output logic link_sel_n,
  output logic link_mosi,
  input wire logic link_miso,
  input wire logic link_miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------
  // Captured bytes
  // ----------------------------------------------------------------------
  logic [7:0] got [0:15];
  logic oe_lost;

  // Link idles with the clock still and the select released
  initial begin
    link_clk = 1'b0;
    link_sel_n = 1'b1;
    link_mosi = 1'b0;
    oe_lost = 1'b0;
  end

  // One frame of n bytes; the clock runs only inside the frame
  task automatic xfer(input logic [7:0] data [0:15], input int n);
    link_sel_n = 1'b0;
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        #40 link_mosi = data[b][i];
        #40 link_clk = 1'b1;
        got[b][i] = link_miso;
        if (link_miso_oe !== 1'b1) begin
          oe_lost = 1'b1;
        end
        #80 link_clk = 1'b0;
      end
    end
    #80 link_sel_n = 1'b1;
    // Released data line shows the inverse, not a stale level
    link_mosi = ~link_mosi;
  endtask : xfer
endmodule : ssr_spi_peer

// ---- sim/sync_serial_status_irq_test.sv ----
// Self-checking bench: register tasks, a peer frame, status and interrupt checks.
// Assumes the design package is compiled first and the peer model beside it.

module sync_serial_status_irq_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys;
  logic arst_n;
  logic bus_wr;
  logic bus_rd;
  logic [11:0] bus_addr;
  logic [31:0] bus_wdata;
  logic [31:0] bus_rdata;
  logic irq_out;
  logic link_clk;
  logic link_sel_n;
  logic link_mosi;
  logic link_miso;
  logic link_miso_oe;
  logic bit_rate_tick;
  logic [7:0] tx_b [0:15];
  logic [7:0] rx_b [0:15];
  int failures;
  int tests_run;
  int ticks;

  // Short time-out keeps the idle wait brief
  ssr_status_irq #(.DEPTH(8), .TIMEOUT_CYC(20)) ssr_status_irq_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq_out(irq_out),
    .link_clk_in(link_clk), .link_sel_n_in(link_sel_n), .link_mosi_in(link_mosi),
    .link_miso_out(link_miso), .link_miso_oe(link_miso_oe), .bit_rate_tick(bit_rate_tick)
  );

  ssr_spi_peer ssr_spi_peer_inst (
    .link_clk(link_clk), .link_sel_n(link_sel_n), .link_mosi(link_mosi),
    .link_miso(link_miso), .link_miso_oe(link_miso_oe)
  );

  // ----------------------------------------------------------------------
  // Clock, verdict and checking tasks
  // ----------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One-cycle write strobe, released at the next edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1 check(bus_rdata, exp);
  endtask : rdc

  // Watchdog: the whole run needs well under 200 us
  initial begin
    #200_000;
    failures++;
    end_sim();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 12'h000;
    bus_wdata = 32'h0000_0000;
    failures = 0;
    tests_run = 0;
    for (int b = 0; b < 16; b++) begin
      tx_b[b] = 8'hA5 ^ 8'(b * 17);
      rx_b[b] = 8'h3C + 8'(b * 29);
    end
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    rdc(ssr_pkg::OFS_STATUS, 32'h0000_0003);
    rdc(ssr_pkg::OFS_PRESCALE, 32'h0000_0000);
    rdc(ssr_pkg::OFS_MASK, 32'h0000_0000);
    rdc(ssr_pkg::OFS_RAW, 32'h0000_0008);
    rdc(12'h0F0, 32'h0000_0000);
    check(32'(irq_out), 32'h0);
    // Odd divisor loses bit zero; upper bits are reserved
    wr(ssr_pkg::OFS_PRESCALE, 32'h0000_00FF);
    rdc(ssr_pkg::OFS_PRESCALE, 32'h0000_00FE);
    wr(ssr_pkg::OFS_PRESCALE, 32'hABCD_0102);
    rdc(ssr_pkg::OFS_PRESCALE, 32'h0000_0002);
    wr(ssr_pkg::OFS_PRESCALE, 32'h0000_0004);
    repeat (4) @(posedge clk_sys);
    ticks = 0;
    repeat (40) begin
      @(posedge clk_sys);
      #1 if (bit_rate_tick === 1'b1) ticks++;
    end
    check(32'(ticks), 32'd10);
    // Mask positions and the interrupt line
    wr(ssr_pkg::OFS_MASK, 32'hFFFF_FFF9);
    rdc(ssr_pkg::OFS_MASK, 32'h0000_0009);
    check(32'(irq_out), 32'h1);
    wr(ssr_pkg::OFS_MASK, 32'h0000_0004);
    rdc(ssr_pkg::OFS_MASKED, 32'h0000_0000);
    check(32'(irq_out), 32'h0);
    wr(ssr_pkg::OFS_MASK, 32'h0000_000F);
    wr(ssr_pkg::OFS_RAW, 32'h0000_0000);
    rdc(ssr_pkg::OFS_RAW, 32'h0000_0008);
    wr(ssr_pkg::OFS_MASKED, 32'h0000_000F);
    rdc(ssr_pkg::OFS_MASKED, 32'h0000_0008);
    // Fill the transmit FIFO to the brim
    for (int k = 1; k <= 8; k++) begin
      wr(ssr_pkg::OFS_DATA, 32'(tx_b[k-1]));
      rdc(ssr_pkg::OFS_STATUS, (k < 8) ? 32'h12 : 32'h10);
      rdc(ssr_pkg::OFS_RAW, (k <= 4) ? 32'h8 : 32'h0);
      check(32'(irq_out), (k <= 4) ? 32'h1 : 32'h0);
    end
    // Nine bytes in: eight fill the receive FIFO, the ninth overruns
    ssr_spi_peer_inst.xfer(rx_b, 9);
    repeat (10) @(posedge clk_sys);
    rdc(ssr_pkg::OFS_STATUS, 32'h0000_000F);
    for (int b = 0; b < 8; b++) begin
      check(32'(ssr_spi_peer_inst.got[b]), 32'(tx_b[b]));
    end
    check(32'(ssr_spi_peer_inst.oe_lost), 32'h0);
    check(32'(link_miso_oe), 32'h0);
    repeat (40) @(posedge clk_sys);
    rdc(ssr_pkg::OFS_RAW, 32'h0000_000F);
    check(32'(irq_out), 32'h1);
    // Latched sources clear only on a written one
    wr(ssr_pkg::OFS_MASK, 32'h0000_0005);
    rdc(ssr_pkg::OFS_MASKED, 32'h0000_0005);
    wr(ssr_pkg::OFS_CLEAR, 32'h0000_0000);
    rdc(ssr_pkg::OFS_RAW, 32'h0000_000F);
    wr(ssr_pkg::OFS_CLEAR, 32'h0000_0002);
    rdc(ssr_pkg::OFS_RAW, 32'h0000_000D);
    wr(ssr_pkg::OFS_CLEAR, 32'h0000_0001);
    rdc(ssr_pkg::OFS_RAW, 32'h0000_000C);
    rdc(ssr_pkg::OFS_MASKED, 32'h0000_0004);
    check(32'(irq_out), 32'h1);
    // Drain the receive FIFO in arrival order
    for (int b = 0; b < 8; b++) begin
      rdc(ssr_pkg::OFS_DATA, 32'(rx_b[b]));
    end
    rdc(ssr_pkg::OFS_STATUS, 32'h0000_0003);
    rdc(ssr_pkg::OFS_RAW, 32'h0000_0008);
    rdc(ssr_pkg::OFS_MASKED, 32'h0000_0000);
    check(32'(irq_out), 32'h0);
    end_sim();
  end
endmodule : sync_serial_status_irq_test
